// ===== verilog/msc_top.sv
// mode decode, mode status and system control registers behind apb
`timescale 1ns/1ps
`default_nettype none
module msc_top
    import msc_pkg::*;
#(
    parameter logic [18:0] P_WAIT_8K   = WAIT_8K,
    parameter logic [18:0] P_WAIT_16K  = WAIT_16K,
    parameter logic [18:0] P_WAIT_32K  = WAIT_32K,
    parameter logic [18:0] P_WAIT_64K  = WAIT_64K,
    parameter logic [18:0] P_WAIT_128K = WAIT_128K,
    parameter logic [18:0] P_WAIT_256K = WAIT_256K
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [2:0]  mode_strap_pins,
    input  wire logic        boot_mode,
    input  wire logic [7:0]  area_width_control,
    input  wire logic        sleep_req,
    input  wire logic        ext_wake,
    input  wire logic        exc_entry,
    input  wire logic        nmi_pin,
    output var  msc_cfg_s    cfg_r,
    output var  logic        sleep_enter_r,
    output var  logic        standby_enter_r,
    output var  logic        settle_busy_r,
    output var  logic        set_imask_r,
    output var  logic        set_uflag_r,
    output var  logic        nmi_req_r
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        msc_pwr_e    pwr;
        logic [7:0]  sysctl;
        logic [2:0]  mds;
        logic [2:0]  strap;
        logic        strap_taken;
        logic [7:0]  abw_prev;
        logic        abw_live;
        logic [18:0] cnt;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        msc_cfg_s    cfg;
        logic        sleep_enter;
        logic        standby_enter;
        logic        settle_busy;
        logic        set_imask;
        logic        set_uflag;
        logic        nmi_prev;
        logic        nmi_req;
    } msc_state_s;

    localparam msc_state_s ST_RESET = '{
        pwr: PWR_RUN, sysctl: SYSCTL_RESET, mds: 3'h0, strap: 3'h0,
        strap_taken: 1'b0, abw_prev: 8'h00, abw_live: 1'b0,
        cnt: 19'h0_0000, pready: 1'b0, pslverr: 1'b0,
        prdata: 32'h0000_0000, cfg: '0, sleep_enter: 1'b0,
        standby_enter: 1'b0, settle_busy: 1'b0, set_imask: 1'b0,
        set_uflag: 1'b0, nmi_prev: 1'b1, nmi_req: 1'b0
    };

    msc_state_s st_r;
    msc_state_s st_nxt;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic hit(input logic [19:0] a, input logic [19:0] base);
        hit = (a[19:2] == base[19:2]);
    endfunction : hit

    function automatic logic [18:0] wait_len(input logic [2:0] sts);
        case (sts)
            3'b000:  wait_len = P_WAIT_8K;
            3'b001:  wait_len = P_WAIT_16K;
            3'b010:  wait_len = P_WAIT_32K;
            3'b011:  wait_len = P_WAIT_64K;
            3'b100:  wait_len = P_WAIT_128K;
            3'b101:  wait_len = P_WAIT_256K;
            3'b110:  wait_len = WAIT_1K;
            // illegal code: longest wait as a safe fallback
            default: wait_len = P_WAIT_256K;
        endcase
    endfunction : wait_len

    function automatic msc_cfg_s decode(input logic [2:0] m, input logic [7:0] sc,
                                        input logic b16);
        msc_cfg_s c;
        logic     exp;
        exp = (m != MODE_NONE) && (m != MODE_7);
        c.mode_valid   = (m != MODE_NONE);
        c.addr_16m     = (m == MODE_3) || (m == MODE_4) || (m == MODE_6);
        c.rom_en       = (m >= MODE_5);
        c.ext_bus_en   = exp;
        c.single_chip  = (m == MODE_7);
        c.bus_16       = exp && b16;
        c.ram_en       = sc[INTERNAL_RAM_ON_BIT];
        c.ram_external = exp && !sc[INTERNAL_RAM_ON_BIT];
        c.ui_is_mask   = !sc[UE_BIT];
        c.nmi_rising   = sc[NONMASKABLE_EDGE_SELECT_BIT];
        decode = c;
    endfunction : decode

    logic        apb_acc;
    logic [2:0]  mds_now;
    logic        init16;
    logic        bus16;
    logic [18:0] exp_len;

    assign apb_acc = psel && penable;
    // top bit inverted while the boot strap is active
    assign mds_now = {boot_mode ^ mode_strap_pins[2], mode_strap_pins[1:0]};
    assign init16  = (st_r.strap == MODE_2) || (st_r.strap == MODE_4);
    // live area widths take over once software touches them
    assign bus16   = st_r.abw_live ? (|area_width_control) : init16;
    assign exp_len = wait_len(st_r.sysctl[STS_HI:STS_LO]);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt               = st_r;
        st_nxt.pready        = 1'b0;
        st_nxt.pslverr       = 1'b0;
        st_nxt.sleep_enter   = 1'b0;
        st_nxt.standby_enter = 1'b0;

        // straps caught once, first edge after release
        if (!st_r.strap_taken) begin
            st_nxt.strap       = mode_strap_pins;
            st_nxt.strap_taken = 1'b1;
        end
        st_nxt.abw_prev = area_width_control;
        if (st_r.strap_taken && (area_width_control != st_r.abw_prev)) begin
            st_nxt.abw_live = 1'b1;
        end
        if (st_r.strap_taken) begin
            st_nxt.cfg = decode(st_r.strap, st_r.sysctl, bus16);
        end

        // apb: one wait cycle, answer prepared in first access cycle
        if (apb_acc && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            if (hit(paddr, ADDR_STATUS)) begin
                st_nxt.mds    = mds_now;
                st_nxt.prdata = {24'h00_0000, STATUS_FIXED | {5'h00, mds_now}};
            end else if (hit(paddr, ADDR_SYSCTL)) begin
                st_nxt.prdata = {24'h00_0000, st_r.sysctl};
            end else begin
                st_nxt.prdata  = 32'h0000_0000;
                st_nxt.pslverr = 1'b1;
            end
        end
        // write commits on the edge where pready is sampled high
        if (apb_acc && st_r.pready && pwrite && hit(paddr, ADDR_SYSCTL)) begin
            st_nxt.sysctl = pwdata[7:0] | SYSCTL_ONES;
        end
        // status writes fall through untouched

        // sleep, standby and settling wait
        case (st_r.pwr)
            PWR_RUN: begin
                if (sleep_req) begin
                    if (st_r.sysctl[STANDBY_SELECT_BIT_BIT]) begin
                        st_nxt.standby_enter = 1'b1;
                        st_nxt.pwr           = PWR_STBY;
                    end else begin
                        st_nxt.sleep_enter = 1'b1;
                    end
                end
            end
            PWR_STBY: begin
                if (ext_wake) begin
                    st_nxt.pwr         = PWR_SETTLE;
                    st_nxt.cnt         = exp_len - 19'h0_0001;
                    st_nxt.settle_busy = 1'b1;
                end
            end
            PWR_SETTLE: begin
                if (st_r.cnt == 19'h0_0000) begin
                    // standby select left set on exit
                    st_nxt.pwr         = PWR_RUN;
                    st_nxt.settle_busy = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt - 19'h0_0001;
                end
            end
            default: begin
                st_nxt.pwr         = PWR_RUN;
                st_nxt.settle_busy = 1'b0;
            end
        endcase

        // exception entry flag updates
        st_nxt.set_imask = exc_entry;
        st_nxt.set_uflag = exc_entry && !st_r.sysctl[UE_BIT];

        // nmi edge detect on chosen polarity
        st_nxt.nmi_prev = nmi_pin;
        st_nxt.nmi_req  = st_r.sysctl[NONMASKABLE_EDGE_SELECT_BIT] ? (nmi_pin && !st_r.nmi_prev)
                                                 : (!nmi_pin && st_r.nmi_prev);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata          = st_r.prdata;
    assign pready          = st_r.pready;
    assign pslverr         = st_r.pslverr;
    assign cfg_r           = st_r.cfg;
    assign sleep_enter_r   = st_r.sleep_enter;
    assign standby_enter_r = st_r.standby_enter;
    assign settle_busy_r   = st_r.settle_busy;
    assign set_imask_r     = st_r.set_imask;
    assign set_uflag_r     = st_r.set_uflag;
    assign nmi_req_r       = st_r.nmi_req;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // straps captured one edge ago, so cfg_r now holds the decoded mode
    logic cfg_ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ok <= 1'b0;
        end else begin
            cfg_ok <= st_r.strap_taken;
        end
    end

    property p_mode_valid;
        cfg_ok |-> (cfg_r.mode_valid == ($past(st_r.strap) != 3'b000));
    endproperty
    a_mode_valid: assert property (p_mode_valid)
        else $error("mode valid flag wrong");

    property p_rom;
        cfg_ok && $past(st_r.strap) != 3'b000 |->
            cfg_r.rom_en == ($past(st_r.strap) >= 3'b101)
            && cfg_r.ext_bus_en == ($past(st_r.strap) != 3'b111);
    endproperty
    a_rom: assert property (p_rom)
        else $error("rom or external access wrong for mode");

    property p_addr;
        cfg_ok |-> cfg_r.addr_16m == ($past(st_r.strap) inside {3'b011, 3'b100, 3'b110});
    endproperty
    a_addr: assert property (p_addr)
        else $error("address space size wrong for mode");

    property p_single;
        cfg_ok && $past(st_r.strap) == 3'b111 |->
            cfg_r.single_chip && !cfg_r.ext_bus_en && !cfg_r.bus_16;
    endproperty
    a_single: assert property (p_single)
        else $error("mode 7 not single chip");

    property p_bus8;
        cfg_ok && $past(st_r.abw_live) && $past(area_width_control) == 8'h00 |->
            !cfg_r.bus_16;
    endproperty
    a_bus8: assert property (p_bus8)
        else $error("bus not 8 bits with all areas 8-bit");

    property p_bus16;
        cfg_ok && $past(st_r.abw_live) && $past(area_width_control) != 8'h00
            && $past(cfg_r.ext_bus_en) |-> cfg_r.bus_16;
    endproperty
    a_bus16: assert property (p_bus16)
        else $error("bus not 16 bits with a 16-bit area");

    property p_bus_init;
        cfg_ok && !$past(st_r.abw_live) && $past(cfg_r.ext_bus_en) |->
            cfg_r.bus_16 == ($past(st_r.strap) inside {3'b010, 3'b100});
    endproperty
    a_bus_init: assert property (p_bus_init)
        else $error("initial bus width wrong for mode");

    property p_ram_ext;
        cfg_ok |-> cfg_r.ram_external == (($past(st_r.strap) inside {[3'b001:3'b110]})
            && !$past(st_r.sysctl[INTERNAL_RAM_ON_BIT]));
    endproperty
    a_ram_ext: assert property (p_ram_ext)
        else $error("ram routing wrong for mode and enable");

    sequence s_status_read;
        apb_acc && !pready && hit(paddr, ADDR_STATUS);
    endsequence

    property p_status_fixed;
        s_status_read |=> pready && prdata[7:3] == 5'b11000 && prdata[31:8] == 24'h00_0000;
    endproperty
    a_status_fixed: assert property (p_status_fixed)
        else $error("status reserved bits wrong");

    property p_status_pins;
        s_status_read |=> prdata[1:0] == $past(mode_strap_pins[1:0])
            && st_r.mds == prdata[2:0];
    endproperty
    a_status_pins: assert property (p_status_pins)
        else $error("status mode bits not latched from pins");

    property p_boot_inv;
        s_status_read |=> prdata[2] == ($past(boot_mode) ^ $past(mode_strap_pins[2]));
    endproperty
    a_boot_inv: assert property (p_boot_inv)
        else $error("boot inversion of top status bit wrong");

    property p_status_nowrite;
        apb_acc && pready && pwrite && hit(paddr, ADDR_STATUS) |=> $stable(st_r.sysctl);
    endproperty
    a_status_nowrite: assert property (p_status_nowrite)
        else $error("status write disturbed registers");

    property p_sysctl_wr;
        apb_acc && pready && pwrite && hit(paddr, ADDR_SYSCTL) |=>
            st_r.sysctl == ($past(pwdata[7:0]) | 8'h02);
    endproperty
    a_sysctl_wr: assert property (p_sysctl_wr)
        else $error("system control write not stored");

    property p_rsv_one;
        st_r.sysctl[1] ##1 st_r.sysctl[1];
    endproperty
    a_rsv_one: assert property (p_rsv_one)
        else $error("reserved control bit not one");

    property p_sleep;
        st_r.pwr == PWR_RUN && sleep_req |=>
            (sleep_enter_r != $past(st_r.sysctl[STANDBY_SELECT_BIT_BIT]))
            && (standby_enter_r == $past(st_r.sysctl[STANDBY_SELECT_BIT_BIT]));
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep request went to wrong mode");

    property p_settle;
        st_r.pwr == PWR_STBY && ext_wake |=>
            settle_busy_r && st_r.cnt == $past(exp_len) - 19'h0_0001;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settling wait length wrong");

    property p_standby_select_bit_keep;
        st_r.pwr == PWR_SETTLE && st_r.cnt == 19'h0_0000 && st_r.sysctl[STANDBY_SELECT_BIT_BIT]
            && !(apb_acc && pwrite) |=> !settle_busy_r && st_r.sysctl[STANDBY_SELECT_BIT_BIT];
    endproperty
    a_standby_select_bit_keep: assert property (p_standby_select_bit_keep)
        else $error("standby select lost on wake");

    property p_exc;
        exc_entry |=> set_imask_r && (set_uflag_r == !$past(st_r.sysctl[UE_BIT]));
    endproperty
    a_exc: assert property (p_exc)
        else $error("exception flag updates wrong");

    property p_nmi;
        $past(nmi_pin) != nmi_pin ##1 1'b1 |->
            nmi_req_r == ($past(nmi_pin, 1) == $past(st_r.sysctl[NONMASKABLE_EDGE_SELECT_BIT], 1));
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("nmi edge polarity wrong");

    property p_ram_keep;
        standby_enter_r |-> st_r.sysctl[INTERNAL_RAM_ON_BIT] == $past(st_r.sysctl[INTERNAL_RAM_ON_BIT]);
    endproperty
    a_ram_keep: assert property (p_ram_keep)
        else $error("ram enable changed on standby entry");

    c_status_read: cover property (s_status_read ##1 pready);
    c_standby_trip: cover property (standby_enter_r ##[1:20] settle_busy_r);
    c_sleep: cover property (sleep_enter_r);
    c_exc_user: cover property (set_uflag_r);

endmodule : msc_top
`default_nettype wire

// ===== shared/msc_pkg.sv
// constants and types for the mode and system control block
// Functional notes
// - strap codes 001..111 select modes 1..7
// - initial bus 8 or 16 bits by mode
// - modes 1-4 external access, rom off
// - modes 5-6 external access, rom on
// - modes 3,4,6 16 MB, others 1 MB
// - mode 7 single chip, all ports free
// - all areas 8-bit gives 8-bit bus once area widths have changed
// - ram off routes ram addresses externally in modes 1-6
// - status reads 11 in 7:6, 000 5:3
// - low status bits latch pins on read
// - boot mode inverts top status bit
// - system control resets to 0x0b
// - standby select picks sleep or standby
// - standby select survives wake, software clears
// - settle field selects wait length
// - usage select: mask flag or user bit
// - edge select: falling or rising nmi
// - control bit 1 reads one, unwritable
// - ram enable resets to one, kept
// - exception entry sets mask, maybe user flag
// - any 16-bit area switches bus to 16 in modes 1-6, once area widths have changed
package msc_pkg;
    localparam logic [15:0] IDX_STATUS   = 16'hfff1;
    localparam logic [15:0] IDX_SYSCTL   = 16'hfff2;
    localparam logic [19:0] ADDR_STATUS  = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [19:0] ADDR_SYSCTL  = {2'b00, IDX_SYSCTL, 2'b00};
    localparam logic [7:0]  STATUS_FIXED = 8'hc0;
    localparam logic [7:0]  SYSCTL_RESET = 8'h0b;
    localparam logic [7:0]  SYSCTL_ONES  = 8'h02;
    localparam int          STANDBY_SELECT_BIT_BIT     = 7;
    localparam int          STS_HI       = 6;
    localparam int          STS_LO       = 4;
    localparam int          UE_BIT       = 3;
    localparam int          NONMASKABLE_EDGE_SELECT_BIT    = 2;
    localparam int          INTERNAL_RAM_ON_BIT     = 0;
    localparam int          CLK_NS       = 5;
    localparam logic [18:0] WAIT_8K      = 19'h0_2000;
    localparam logic [18:0] WAIT_16K     = 19'h0_4000;
    localparam logic [18:0] WAIT_32K     = 19'h0_8000;
    localparam logic [18:0] WAIT_64K     = 19'h1_0000;
    localparam logic [18:0] WAIT_128K    = 19'h2_0000;
    localparam logic [18:0] WAIT_256K    = 19'h4_0000;
    localparam logic [18:0] WAIT_1K      = 19'h0_0400;

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000, MODE_1 = 3'b001, MODE_2 = 3'b010, MODE_3 = 3'b011,
        MODE_4 = 3'b100, MODE_5 = 3'b101, MODE_6 = 3'b110, MODE_7 = 3'b111
    } msc_mode_e;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00, PWR_STBY = 2'b01, PWR_SETTLE = 2'b10
    } msc_pwr_e;

    typedef struct packed {
        logic mode_valid;
        logic addr_16m;
        logic rom_en;
        logic ext_bus_en;
        logic single_chip;
        logic bus_16;
        logic ram_en;
        logic ram_external;
        logic ui_is_mask;
        logic nmi_rising;
    } msc_cfg_s;
endpackage : msc_pkg

// ===== bench/msc_strap_model.sv
// board strap model that presents and holds the mode pins
`timescale 1ns/1ps
`default_nettype none
module msc_strap_model (
    input  wire logic       presetn,
    input  wire logic [2:0] code_sel,
    input  wire logic       boot_sel,
    output var  logic [2:0] mode_strap_pins,
    output var  logic       boot_mode
);
    // straps follow the selection only while reset is held, then stay put
    always_latch begin
        if (!presetn) begin
            mode_strap_pins = code_sel;
            boot_mode       = boot_sel;
        end
    end
endmodule : msc_strap_model
`default_nettype wire

// ===== bench/test_mode_and_system_control.sv
// self-checking bench for the mode and system control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_mode_and_system_control;
    import msc_pkg::*;
    localparam int WL [8] = '{int'(WAIT_8K), 24, 32, 40, 48, 56, 1024, 56};
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, er, boot_mode, boot_sel = 1'b0;
    logic [2:0]  mode_strap_pins, code_sel = 3'h1;
    logic [7:0]  awc = '0, wv, aw;
    logic        sleep_req = 1'b0, ext_wake = 1'b0, exc_entry = 1'b0, nmi_pin = 1'b1;
    msc_cfg_s    cfg_r;
    logic        sl, sb, st, im, uf, nq;
    int          n_fail = 0, checks_done = 0, m, c, k0, k1;
    int          n_sl = 0, n_sb = 0, n_st = 0, n_im = 0, n_uf = 0, n_nq = 0;

    msc_strap_model strap (.presetn(presetn), .code_sel(code_sel), .boot_sel(boot_sel),
        .mode_strap_pins(mode_strap_pins), .boot_mode(boot_mode));
    msc_top #(.P_WAIT_16K(19'd24), .P_WAIT_32K(19'd32),
        .P_WAIT_64K(19'd40), .P_WAIT_128K(19'd48), .P_WAIT_256K(19'd56)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_strap_pins(mode_strap_pins), .boot_mode(boot_mode), .area_width_control(awc),
        .sleep_req(sleep_req), .ext_wake(ext_wake), .exc_entry(exc_entry), .nmi_pin(nmi_pin),
        .cfg_r(cfg_r), .sleep_enter_r(sl), .standby_enter_r(sb), .settle_busy_r(st),
        .set_imask_r(im), .set_uflag_r(uf), .nmi_req_r(nq));

    initial begin
        pclk = 1'b0;
        forever #(CLK_NS / 2.0) pclk = ~pclk;
    end

    // pulse and level counters on the control outputs
    always @(posedge pclk) begin
        n_sl += (sl === 1'b1);
        n_sb += (sb === 1'b1);
        n_st += (st === 1'b1);
        n_im += (im === 1'b1);
        n_uf += (uf === 1'b1);
        n_nq += (nq === 1'b1);
    end

    // ******************************************
    // model and bus tasks
    // ******************************************
    function automatic msc_cfg_s exp_cfg(int m, logic [7:0] c, bit chg, logic [7:0] a);
        msc_cfg_s e;
        e.mode_valid   = 1'b1;
        e.addr_16m     = (m == 3 || m == 4 || m == 6);
        e.rom_en       = (m >= 5);
        e.ext_bus_en   = (m < 7);
        e.single_chip  = (m == 7);
        e.bus_16       = (m < 7) && (chg ? (|a) : (m == 2 || m == 4));
        e.ram_en       = c[0];
        e.ram_external = (m < 7) && !c[0];
        e.ui_is_mask   = !c[3];
        e.nmi_rising   = c[2];
        return e;
    endfunction : exp_cfg

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) n_fail++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input int w);
        @(posedge pclk);
        case (w)
            0: sleep_req <= 1'b1;
            1: ext_wake <= 1'b1;
            default: exc_entry <= 1'b1;
        endcase
        @(posedge pclk);
        sleep_req <= 1'b0;
        ext_wake  <= 1'b0;
        exc_entry <= 1'b0;
        step(4);
    endtask : pulse

    task automatic do_reset(input int m, input bit b);
        @(posedge pclk);
        presetn  <= 1'b0;
        code_sel <= m[2:0];
        boot_sel <= b;
        awc      <= '0;
        step(5);
        presetn  <= 1'b1;
        step(3);
    endtask : do_reset

    task automatic conclude();
        $display("fails=%0d checks=%0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude

    initial begin
        #(CLK_NS * 40000);
        n_fail++;
        conclude();
    end

    // ******************************************
    // scenarios
    // ******************************************
    initial begin
        void'($urandom(26));
        for (m = 1; m < 8; m++) begin
            do_reset(m, m == 5);
            `CHK(cfg_r, exp_cfg(m, SYSCTL_RESET, 0, 0))
            apb(1'b0, ADDR_SYSCTL, '0);
            `CHK(rd, 32'h0000_000b)
            apb(1'b1, ADDR_STATUS, 32'h0000_00ff);
            apb(1'b0, ADDR_STATUS, '0);
            `CHK(rd, {24'h0, 2'b11, 3'b000, m[2] ^ (m == 5), m[1:0]})
            wv = 8'($urandom);
            apb(1'b1, ADDR_SYSCTL, {24'h0, wv});
            apb(1'b0, ADDR_SYSCTL, '0);
            `CHK(rd, {24'h0, wv | 8'h02})
            step(3);
            `CHK(cfg_r, exp_cfg(m, wv | 8'h02, 0, 0))
            if (m < 7) begin
                aw = 8'($urandom_range(1, 255));
                awc <= aw;
                step(3);
                `CHK(cfg_r, exp_cfg(m, wv | 8'h02, 1, aw))
                awc <= '0;
                step(3);
                `CHK(cfg_r, exp_cfg(m, wv | 8'h02, 1, 8'h00))
            end
        end
        apb(1'b0, 20'h3_ffcc, '0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1'b1, ADDR_SYSCTL, 32'h0000_0003);
        k0 = n_sl;
        k1 = n_sb;
        pulse(0);
        `CHK({n_sl - k0, n_sb - k1}, {32'd1, 32'd0})
        k0 = n_im;
        k1 = n_uf;
        pulse(2);
        `CHK({n_im - k0, n_uf - k1}, {32'd1, 32'd1})
        apb(1'b1, ADDR_SYSCTL, 32'h0000_000b);
        pulse(2);
        `CHK({n_im - k0, n_uf - k1}, {32'd2, 32'd1})
        // falling then rising pin, under each edge selection
        for (c = 0; c < 2; c++) begin
            apb(1'b1, ADDR_SYSCTL, {24'h0, 8'h0b | 8'(c << 2)});
            k0 = n_nq;
            nmi_pin <= 1'b0;
            step(5);
            `CHK(n_nq - k0, 1 - c)
            nmi_pin <= 1'b1;
            step(5);
            `CHK(n_nq - k0, 1)
        end
        for (c = 0; c < 8; c++) begin
            // settle codes swept, 000 and 110 on full-length waits, others scaled, oscillator floor not modelled
            wv = 8'h8b | 8'(c << 4);
            apb(1'b1, ADDR_SYSCTL, {24'h0, wv});
            k0 = n_sb;
            k1 = n_st;
            pulse(0);
            `CHK(n_sb - k0, 1)
            pulse(1);
            step(WL[c] + 4);
            `CHK(n_st - k1, WL[c])
            apb(1'b0, ADDR_SYSCTL, '0);
            `CHK(rd, {24'h0, wv})
        end
        conclude();
    end
endmodule : test_mode_and_system_control
`default_nettype wire
